/* File: hw/pattern_tester_pkg.sv */
// Shared constants of the block pattern stream tester.
// Assumes one user clock; no other package is needed.
package pattern_tester_pkg;
	localparam int WORD_W = 128;
	localparam int DWORD_W = 32;
	localparam int DWORDS_PER_WORD = 4;
	localparam int ADDR_W = 48;
	localparam int BEAT_W = 8;
	localparam int BEATS_PER_BLOCK = 256;
	localparam logic [7:0] LAST_BEAT = 8'hFF;
	localparam int HDR_FIFO_DEPTH = 1024;
	localparam int BUF_DEPTH = 2;
	// Header layout inside the first word
	localparam int HDR_LO_POS = 0;
	localparam int HDR_HI_POS = 32;
	localparam logic [15:0] HDR_PAD = 16'h0000;
	// Pattern select encoding
	localparam logic [2:0] PAT_INC = 3'h0;
	localparam logic [2:0] PAT_DEC = 3'h1;
	localparam logic [2:0] PAT_LFSR = 3'h2;
	localparam logic [2:0] PAT_ZERO = 3'h3;
	localparam logic [2:0] PAT_ONE = 3'h4;
	// Per-block LFSR start value; must not be zero
	localparam logic [31:0] LFSR_SEED = 32'h0000_0001;
	// Feedback tap positions of x^31 + x^21 + x + 1
	localparam int TAP_A = 31;
	localparam int TAP_B = 21;
	localparam int TAP_C = 1;
	typedef enum logic [1:0] {
		st_wait_cmd,
		st_send_block,
		st_settle
	} wr_state_t;
endpackage : pattern_tester_pkg

/* File: hw/word_stream_if.sv */
// Valid/ready word channel between the tester and its output buffer.
// Assumes both ends share one clock.
interface word_stream_if #(parameter int W = 128);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface : word_stream_if

/* File: hw/two_entry_buffer.sv */
// Two-entry buffer with valid/ready on both sides.
// Assumes a synchronous active-high reset on the shared clock.
module two_entry_buffer
	import pattern_tester_pkg::*;
#(
	parameter int W = WORD_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Filling side
	word_stream_if.snk inS,
	// Draining side
	word_stream_if.src outS
);
	logic [W-1:0] mem [BUF_DEPTH];
	logic wrPtr_r;
	logic rdPtr_r;
	logic [1:0] count_r;
	logic [1:0] count_nxt;
	wire push = inS.valid && inS.ready;
	wire pop = outS.valid && outS.ready;

	// Two entries let the source keep streaming for a cycle after a stall
	assign inS.ready = (count_r != 2'h2);
	assign outS.valid = (count_r != 2'h0);
	assign outS.data = mem[rdPtr_r];
	assign count_nxt = count_r + {1'b0, push} - {1'b0, pop};

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_r] <= inS.data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wrPtr_r <= 1'b0;
			rdPtr_r <= 1'b0;
			count_r <= 2'h0;
		end else begin
			wrPtr_r <= wrPtr_r ^ push;
			rdPtr_r <= rdPtr_r ^ pop;
			count_r <= count_nxt;
		end
	end
endmodule : two_entry_buffer

/* File: hw/block_pattern_stream_tester.sv */
// Block pattern stream tester: sources and checks 4 Kbyte test blocks.
// Assumes the host streams are synchronous to clk and that the header
// address FIFO is filled by software through the push port.
//
// Summary of operation
// - Write waits for header address and ready.
// - One-cycle header pop, then send block.
// - Valid held until 256 words are accepted, one word each.
// - 8-bit beat counter counts words per block.
// - One settle cycle after last word.
// - Direction low writes, high verifies reads.
// - First two dwords carry address header.
// - Remaining dwords carry incrementing, decrementing or LFSR.
// - Decrementing data is inverted incrementing counter.
// - LFSR x^31+x^21+x+1, four steps per word.
// - All-zero or all-one blocks, no header.
// - Read words compared; mismatch raises fail flag.
// - Read valid rising edge pops header address.
// - Delayed valid enables compare; data registered once.
// - Both streams are 128 bits wide.
// - Header FIFO holds 1024 48-bit addresses.
module block_pattern_stream_tester
	import pattern_tester_pkg::*;
#(
	parameter int FIFO_DEPTH = HDR_FIFO_DEPTH,
	parameter logic [31:0] SEED = LFSR_SEED
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Header address push from software
	input wire logic hdrPushValid,
	input wire logic [ADDR_W-1:0] hdrPushAddr,
	output logic hdrFifoFull,
	output logic [$clog2(FIFO_DEPTH):0] hdrFifoCount,
	output logic headerFifoEmpty,
	// Control and status
	input wire logic readDirection,
	input wire logic [2:0] patternSelect,
	input wire logic verifyFailClear,
	output logic verifyFailFlag,
	output logic [BEAT_W-1:0] beatCount,
	output logic wrBusy,
	// Write stream to the host
	output logic wrStreamValid,
	input wire logic wrStreamReady,
	output logic [WORD_W-1:0] wrStreamWord,
	// Read stream from the host
	input wire logic rdStreamValid,
	input wire logic [WORD_W-1:0] rdStreamWord
);
	localparam int PTR_W = $clog2(FIFO_DEPTH);
	localparam logic [PTR_W:0] DEPTH_CNT = FIFO_DEPTH[PTR_W:0];

	// One LFSR step, shift left with feedback into bit 0
	function automatic logic [31:0] lfsrStep(input logic [31:0] s);
		lfsrStep = {s[30:0], s[TAP_A] ^ s[TAP_B] ^ s[TAP_C]};
	endfunction : lfsrStep

	// ---------------- Header address FIFO ----------------
	logic [ADDR_W-1:0] hdrMem [FIFO_DEPTH];
	logic [PTR_W-1:0] hdrWrPtr_r;
	logic [PTR_W-1:0] hdrRdPtr_r;
	logic [PTR_W:0] hdrCount_r;
	logic headerFifoPop;
	wire hdrPush = hdrPushValid && !hdrFifoFull;
	wire [ADDR_W-1:0] hdrHead = hdrMem[hdrRdPtr_r];

	assign hdrFifoFull = (hdrCount_r == DEPTH_CNT);
	assign headerFifoEmpty = (hdrCount_r == '0);
	assign hdrFifoCount = hdrCount_r;

	always_ff @(posedge clk) begin
		if (hdrPush) begin
			hdrMem[hdrWrPtr_r] <= hdrPushAddr;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hdrWrPtr_r <= '0;
			hdrRdPtr_r <= '0;
			hdrCount_r <= '0;
		end else begin
			hdrWrPtr_r <= hdrWrPtr_r + PTR_W'(hdrPush);
			hdrRdPtr_r <= hdrRdPtr_r + PTR_W'(headerFifoPop);
			hdrCount_r <= hdrCount_r + (PTR_W+1)'(hdrPush)
				- (PTR_W+1)'(headerFifoPop);
		end
	end

	// ---------------- Write control ----------------
	wr_state_t state_r;
	wr_state_t state_nxt;
	logic [BEAT_W-1:0] beatCounter_r;
	logic [ADDR_W-1:0] blockAddr_r;
	logic [31:0] lfsr_r;
	logic rdValidPrev_r;

	word_stream_if #(.W(WORD_W)) genS();
	word_stream_if #(.W(WORD_W)) bufS();

	wire writeMode = !readDirection;
	wire wrStart = writeMode && (state_r == st_wait_cmd)
		&& !headerFifoEmpty && wrStreamReady;
	wire sendFire = (state_r == st_send_block) && genS.ready;
	wire rdBeat = readDirection && rdStreamValid;
	wire rdStart = rdBeat && !rdValidPrev_r;
	wire beatAdvance = writeMode ? sendFire : rdBeat;
	wire lastBeat = (beatCounter_r == LAST_BEAT);

	// Read pop is guarded so an empty FIFO is never underrun
	assign headerFifoPop = wrStart || (rdStart && !headerFifoEmpty);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			st_wait_cmd: begin
				if (wrStart) begin
					state_nxt = st_send_block;
				end
			end
			st_send_block: begin
				if (sendFire && lastBeat) begin
					state_nxt = st_settle;
				end
			end
			st_settle: begin
				// Gives the host one cycle to update write ready
				state_nxt = st_wait_cmd;
			end
			default: begin
				state_nxt = st_wait_cmd;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= st_wait_cmd;
			beatCounter_r <= '0;
			rdValidPrev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			// Eight bits wrap to zero after the last beat of a block
			beatCounter_r <= beatCounter_r + BEAT_W'(beatAdvance);
			rdValidPrev_r <= rdBeat;
		end
	end

	// ---------------- Test data generator ----------------
	// On the first read beat the FIFO head and the seed are used directly,
	// so the expected first word matches without an extra cycle.
	wire [ADDR_W-1:0] genAddr = rdStart ? hdrHead : blockAddr_r;
	wire [31:0] genLfsr = rdStart ? SEED : lfsr_r;
	wire isHeaderBeat = (beatCounter_r == '0);
	wire usesHeader = (patternSelect == PAT_INC)
		|| (patternSelect == PAT_DEC) || (patternSelect == PAT_LFSR);
	logic [31:0] lfsrAhead [DWORDS_PER_WORD+1];
	logic [WORD_W-1:0] patWord;
	logic [WORD_W-1:0] genWord;

	assign lfsrAhead[0] = genLfsr;

	genvar gi;
	generate
		for (gi = 0; gi < DWORDS_PER_WORD; gi++) begin : g_dw
			// Incrementing value is the dword index within the block
			wire [31:0] incDw = {22'h000000, beatCounter_r, 2'(gi)};
			assign lfsrAhead[gi+1] = lfsrStep(lfsrAhead[gi]);
			assign patWord[gi*DWORD_W +: DWORD_W] =
				(patternSelect == PAT_INC) ? incDw :
				(patternSelect == PAT_DEC) ? ~incDw :
				(patternSelect == PAT_LFSR) ? lfsrAhead[gi+1] :
				(patternSelect == PAT_ONE) ? 32'hFFFF_FFFF :
				32'h0000_0000;
		end
	endgenerate

	always_comb begin
		genWord = patWord;
		if (usesHeader && isHeaderBeat) begin
			genWord[HDR_LO_POS +: DWORD_W] = genAddr[31:0];
			genWord[HDR_HI_POS +: DWORD_W] = {HDR_PAD, genAddr[47:32]};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			blockAddr_r <= '0;
			lfsr_r <= SEED;
		end else if (headerFifoPop) begin
			blockAddr_r <= hdrHead;
			lfsr_r <= rdStart ? lfsrAhead[DWORDS_PER_WORD] : SEED;
		end else if (beatAdvance) begin
			lfsr_r <= lfsrAhead[DWORDS_PER_WORD];
		end
	end

	// ---------------- Write stream path ----------------
	assign genS.valid = (state_r == st_send_block);
	assign genS.data = genWord;

	two_entry_buffer #(.W(WORD_W)) u_out_buf (
		.clk(clk),
		.sys_rst(sys_rst),
		.inS(genS),
		.outS(bufS)
	);

	assign wrStreamValid = bufS.valid;
	assign wrStreamWord = bufS.data;
	assign bufS.ready = wrStreamReady;

	// ---------------- Read verification ----------------
	logic rdValidD1_r;
	logic [WORD_W-1:0] expectedWord_r;
	logic [WORD_W-1:0] rdWordD1_r;
	logic verifyFail_r;
	wire mismatch = rdValidD1_r && (rdWordD1_r != expectedWord_r);

	always_ff @(posedge clk) begin
		if (rdBeat) begin
			expectedWord_r <= genWord;
			rdWordD1_r <= rdStreamWord;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdValidD1_r <= 1'b0;
			verifyFail_r <= 1'b0;
		end else begin
			rdValidD1_r <= rdBeat;
			// A mismatch in the clearing cycle still sets the flag
			if (mismatch) begin
				verifyFail_r <= 1'b1;
			end else if (verifyFailClear) begin
				verifyFail_r <= 1'b0;
			end
		end
	end

	assign verifyFailFlag = verifyFail_r;
	assign beatCount = beatCounter_r;
	assign wrBusy = (state_r != st_wait_cmd);
endmodule : block_pattern_stream_tester

/* File: sim/block_pattern_stream_tester_assertions.sv */
// Port checker for the block pattern stream tester.
// Assumes one clock and a reset held two cycles or more.
module pattern_tester_checker
	import pattern_tester_pkg::*;
#(
	parameter int FIFO_DEPTH = 1024
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Watched ports
	input wire logic hdrPushValid,
	input wire logic hdrFifoFull,
	input wire logic [$clog2(FIFO_DEPTH):0] hdrFifoCount,
	input wire logic headerFifoEmpty,
	input wire logic readDirection,
	input wire logic verifyFailClear,
	input wire logic verifyFailFlag,
	input wire logic [BEAT_W-1:0] beatCount,
	input wire logic wrBusy,
	input wire logic wrStreamValid,
	input wire logic wrStreamReady,
	input wire logic [WORD_W-1:0] wrStreamWord,
	input wire logic rdStreamValid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence lastBeat;
		wrBusy && beatCount == LAST_BEAT ##1 beatCount == 8'h00;
	endsequence
	a_write_start: assert property (!readDirection && !wrBusy &&
		!headerFifoEmpty && wrStreamReady |=> wrBusy) else $error("no start");
	a_idle_wait: assert property (!wrBusy && (readDirection ||
		headerFifoEmpty || !wrStreamReady) |=> !wrBusy) else $error("early");
	a_write_pop: assert property ($rose(wrBusy) |-> hdrFifoCount ==
		$past(hdrFifoCount) - 1 + $past(hdrPushValid && !hdrFifoFull))
		else $error("write pop count");
	a_read_pop: assert property (readDirection && $rose(rdStreamValid) &&
		!headerFifoEmpty |=> hdrFifoCount == $past(hdrFifoCount) - 1 +
		$past(hdrPushValid && !hdrFifoFull)) else $error("read pop count");
	a_word_held: assert property (wrStreamValid && !wrStreamReady |=>
		wrStreamValid && $stable(wrStreamWord)) else $error("word lost");
	a_beat_step: assert property (beatCount != $past(beatCount) |->
		beatCount == $past(beatCount) + 8'h01) else $error("beat step");
	a_settle_once: assert property (lastBeat |-> wrBusy ##1 !wrBusy)
		else $error("settle");
	a_fail_sticky: assert property (verifyFailFlag && !verifyFailClear
		|=> verifyFailFlag) else $error("flag dropped");
	a_write_nofail: assert property (!readDirection [*3] ##0
		!verifyFailFlag |=> !verifyFailFlag) else $error("flag in write");
	a_fifo_flags: assert property (hdrFifoFull == (hdrFifoCount ==
		FIFO_DEPTH) && headerFifoEmpty == (hdrFifoCount == 0))
		else $error("fifo flags");
endmodule : pattern_tester_checker

bind block_pattern_stream_tester pattern_tester_checker #(
	.FIFO_DEPTH(FIFO_DEPTH)) chk (.clk, .sys_rst, .hdrPushValid,
	.hdrFifoFull, .hdrFifoCount, .headerFifoEmpty, .readDirection,
	.verifyFailClear, .verifyFailFlag, .beatCount, .wrBusy, .wrStreamValid,
	.wrStreamReady, .wrStreamWord, .rdStreamValid);

/* File: sim/host_stream_model.sv */
// Host side model: takes written blocks, plays them back as reads.
// Assumes the bench drives stall, go and corrupt on clock edges.
module host_stream_model
	import pattern_tester_pkg::*;
(
	// Clock
	input wire logic clk,
	// Bench control
	input wire logic stall,
	input wire logic go,
	input wire logic corrupt,
	// Write stream
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [WORD_W-1:0] wrWord,
	// Read stream
	output logic rdValid,
	output logic [WORD_W-1:0] rdWord
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WORD_W-1:0] mem [BEATS_PER_BLOCK];
	int nWr = 0;
	int nRd = 0;
	logic [3:0] tick = 4'h0;
	// Bursts of low ready fill the tester's buffer
	assign wrReady = !(stall && tick[2]);
	// Read outputs have one driver; the first edge, inside reset, settles rdValid
	always @(posedge clk) begin
		tick <= tick + 4'h1;
		if (wrValid && wrReady) begin
			mem[nWr[7:0]] <= wrWord;
			nWr <= nWr + 1;
		end
		if (go || nRd != 0) begin
			rdValid <= 1'h1;
			rdWord <= mem[8'(nWr + nRd)] ^ {127'h0, corrupt && nRd == 100};
			nRd <= (nRd == 255) ? 0 : nRd + 1;
		end else begin
			// Idle data toggles so stale words never look valid
			rdValid <= 1'h0;
			rdWord <= ~rdWord;
		end
	end
endmodule : host_stream_model

/* File: sim/tb_block_pattern_stream_tester.sv */
// Self-checking bench: writes blocks, reads them back, checks flags.
// Assumes the host model and the checker bind are compiled with it.
module tb_block_pattern_stream_tester
	import pattern_tester_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [2:0] pat;
		logic [47:0] addr;
		logic stl;
		logic bad;
	} row_t;
	row_t rows [7] = '{'{PAT_INC, 48'h0123_4567_89AB, 1'h0, 1'h0},
		'{PAT_DEC, 48'hFEDC_BA98_7654, 1'h0, 1'h0},
		'{PAT_LFSR, 48'h8000_0000_0001, 1'h1, 1'h0},
		'{PAT_ZERO, 48'h5555_AAAA_5555, 1'h1, 1'h0},
		'{PAT_ONE, 48'h0000_0000_0000, 1'h0, 1'h0},
		'{3'h5, 48'h1234_5678_9ABC, 1'h0, 1'h0},
		'{PAT_LFSR, 48'hFFFF_FFFF_FFFF, 1'h0, 1'h1}};
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	logic hdrPushValid = 1'h0;
	logic [47:0] hdrPushAddr = 48'h0;
	logic readDirection = 1'h0;
	logic [2:0] patternSelect = 3'h0;
	logic verifyFailClear = 1'h0;
	logic stall = 1'h0;
	logic go = 1'h0;
	logic corrupt = 1'h0;
	logic hdrFifoFull, headerFifoEmpty, verifyFailFlag, wrBusy;
	logic wrStreamValid, wrStreamReady, rdStreamValid;
	logic [10:0] hdrFifoCount;
	logic [7:0] beatCount;
	logic [127:0] wrStreamWord, rdStreamWord;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	block_pattern_stream_tester dut (.clk, .sys_rst, .hdrPushValid,
		.hdrPushAddr, .hdrFifoFull, .hdrFifoCount, .headerFifoEmpty,
		.readDirection, .patternSelect, .verifyFailClear, .verifyFailFlag,
		.beatCount, .wrBusy, .wrStreamValid, .wrStreamReady, .wrStreamWord,
		.rdStreamValid, .rdStreamWord);
	host_stream_model host (.clk, .stall, .go, .corrupt,
		.wrValid(wrStreamValid), .wrReady(wrStreamReady),
		.wrWord(wrStreamWord), .rdValid(rdStreamValid), .rdWord(rdStreamWord));
	always #12.5 clk = ~clk;
	task finish_test;
		if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	task cmpWord(string nm, logic [127:0] e, logic [127:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : cmpWord
	task cmpBit(string nm, logic [15:0] e, logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : cmpBit
	function automatic logic [127:0] expW(logic [2:0] p, logic [47:0] a,
		int b);
		logic [127:0] w;
		logic [31:0] s;
		logic [31:0] d;
		s = LFSR_SEED;
		for (int k = 0; k < 4 * b + 4; k++) begin
			s = {s[30:0], s[31] ^ s[21] ^ s[1]};
			d = 32'(k - 4 * b);
			d = 32'(4 * b) + d;
			case (p)
				PAT_INC: d = d;
				PAT_DEC: d = ~d;
				PAT_LFSR: d = s;
				PAT_ONE: d = 32'hFFFF_FFFF;
				default: d = 32'h0;
			endcase
			if (k >= 4 * b)
				w[32 * (k - 4 * b) +: 32] = d;
		end
		if (b == 0 && p < PAT_ZERO)
			w[63:0] = {HDR_PAD, a};
		return w;
	endfunction : expW
	task push(logic [47:0] a);
		hdrPushValid <= 1'h1;
		hdrPushAddr <= a;
		@(posedge clk);
		hdrPushValid <= 1'h0;
		@(posedge clk);
	endtask : push
	task automatic runBlock(row_t r);
		int base;
		logic [127:0] e;
		base = host.nWr;
		patternSelect <= r.pat;
		stall <= r.stl;
		readDirection <= 1'h0;
		push(r.addr);
		for (int k = 0; k < 2000 && host.nWr < base + 256; k++)
			@(posedge clk);
		repeat (4) @(posedge clk);
		cmpBit("busy", 16'h0, 16'(wrBusy));
		for (int b = 0; b < 256; b++) begin
			e = expW(r.pat, r.addr, b);
			cmpWord("word", e, host.mem[8'(base + b)]);
		end
		readDirection <= 1'h1;
		corrupt <= r.bad;
		push(r.addr);
		go <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		repeat (262) @(posedge clk);
		cmpBit("fail", 16'(r.bad), 16'(verifyFailFlag));
		cmpBit("beat", 16'h0, 16'(beatCount));
		cmpBit("count", 16'h0, 16'(hdrFifoCount));
		verifyFailClear <= 1'h1;
		corrupt <= 1'h0;
		@(posedge clk);
		verifyFailClear <= 1'h0;
		@(posedge clk);
		cmpBit("clear", 16'h0, 16'(verifyFailFlag));
	endtask : runBlock
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
		@(posedge clk);
		cmpBit("reset", 16'h0800, {4'h0, headerFifoEmpty, wrBusy,
			wrStreamValid, verifyFailFlag, beatCount});
		foreach (rows[i])
			runBlock(rows[i]);
		// Pushes beyond the depth must be dropped
		hdrPushValid <= 1'h1;
		repeat (1030) @(posedge clk);
		hdrPushValid <= 1'h0;
		@(posedge clk);
		cmpBit("count", 16'h0400, 16'(hdrFifoCount));
		cmpBit("full", 16'h1, 16'(hdrFifoFull));
		readDirection <= 1'h0;
		repeat (50) @(posedge clk);
		sys_rst <= 1'h1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
		@(posedge clk);
		cmpBit("reset", 16'h0800, {4'h0, headerFifoEmpty, wrBusy,
			wrStreamValid, verifyFailFlag, beatCount});
		runBlock(rows[2]);
		finish_test();
	end
endmodule : tb_block_pattern_stream_tester
